// [verification/csr_core_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire csr_pkg::csr_sfr_req_t sfr_req,
  input wire logic sfr_hit,
  input wire logic [7:0] sfr_rdata,
  input wire csr_pkg::csr_bit_req_t bit_req,
  input wire csr_pkg::csr_alu_req_t alu_req,
  input wire csr_pkg::csr_stack_req_t stack_req,
  input wire csr_pkg::csr_stack_mem_t stack_mem,
  input wire logic pointer_inc,
  input wire logic [15:0] indirect_pointer,
  input wire logic [4:0] bank_base,
  input wire logic [7:0] stack_top_pointer,
  input wire logic [7:0] primary_operand,
  input wire logic [7:0] secondary_operand,
  input wire logic [7:0] status_word
);
  import csr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // no byte or bit write that could override arithmetic results
  logic quiet;
  assign quiet = !sfr_req.wr && !bit_req.wr;
  a_reset_values: assert property (disable iff (1'b0) !rst_b |=>
    stack_top_pointer == 8'h07 && indirect_pointer == 16'h0000) else $error("bad reset");
  a_push_preinc: assert property (stack_req.push |=> stack_mem.wr &&
    stack_mem.addr == 8'($past(stack_top_pointer) + 8'h01)) else $error("bad push");
  a_pop_postdec: assert property (stack_req.pop && !stack_req.push &&
    !(sfr_req.wr && sfr_req.addr == 8'h81) |=> stack_mem.rd &&
    stack_mem.addr == $past(stack_top_pointer) &&
    stack_top_pointer == 8'($past(stack_top_pointer) - 8'h01)) else $error("bad pop");
  a_low_byte_alone: assert property (sfr_req.wr && sfr_req.addr == 8'h82 &&
    !pointer_inc |=> indirect_pointer[7:0] == $past(sfr_req.wdata) &&
    $stable(indirect_pointer[15:8])) else $error("bad pointer");
  a_bank_follows: assert property (bank_base == {status_word[4:3], 3'b000})
    else $error("bad bank");
  a_parity_live: assert property (status_word[0] == ^primary_operand)
    else $error("bad parity");
  a_user_bits_kept: assert property (quiet |=> status_word[5] == $past(status_word[5]) &&
    status_word[1] == $past(status_word[1])) else $error("user bit moved");
  a_add_flags: assert property (alu_req.op == CSR_OP_ADD && quiet |=>
    {status_word[7], primary_operand} == 9'($past(primary_operand)) +
    9'($past(alu_req.operand)) && status_word[6] ==
    ($past(primary_operand[3:0]) + $past(alu_req.operand[3:0]) > 5'd15)) else $error("bad add");
  a_product_split: assert property (alu_req.op == CSR_OP_PRODUCT && quiet |=>
    {secondary_operand, primary_operand} == 16'($past(primary_operand)) *
    16'($past(secondary_operand)) && status_word[2] == (secondary_operand != 8'h00))
    else $error("bad product");
  a_read_accum: assert property (sfr_req.rd && sfr_req.addr == 8'hE0 |=>
    sfr_rdata == $past(primary_operand)) else $error("bad read");
endmodule : csr_core_regs_sva
`default_nettype wire

// [verification/tb_cpu_core_special_registers.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core_special_registers;
  import csr_pkg::*;
  logic clk, rst_b, pointer_inc, sfr_hit;
  csr_sfr_req_t sfr_req;
  csr_bit_req_t bit_req;
  csr_alu_req_t alu_req;
  csr_stack_req_t stack_req;
  csr_stack_mem_t stack_mem;
  logic [15:0] indirect_pointer;
  logic [7:0] sfr_rdata, stack_top_pointer, primary_operand, secondary_operand, status_word;
  logic [4:0] bank_base;
  logic [7:0] adr [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  int miscompares = 0;
  int total_checks = 0;
  csr_core_regs i_csr_core_regs (.clk, .rst_b, .sfr_req, .sfr_hit, .sfr_rdata, .bit_req,
    .alu_req, .stack_req, .stack_mem, .pointer_inc, .indirect_pointer, .bank_base,
    .stack_top_pointer, .primary_operand, .secondary_operand, .status_word);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // requests last one cycle, then all drop together
  task automatic go;
    @(negedge clk);
    sfr_req = '0;
    bit_req = '0;
    alu_req = '0;
    stack_req = '0;
    pointer_inc = 1'b0;
  endtask : go
  // only defined register bits are ever written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{1'b0, 1'b1, a, d};
    go;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_req = '{1'b1, 1'b0, a, 8'h00};
    #1 chk(16'(sfr_hit), 16'(a inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0}));
    go;
    chk(16'(sfr_rdata), 16'(exp));
  endtask : rd
  task automatic alu(input csr_alu_op_t op, input logic [7:0] o, input logic [7:0] s);
    @(negedge clk);
    alu_req = '{op, o};
    go;
    chk(16'(status_word), 16'(s));
  endtask : alu
  task automatic stk(input logic pu, input logic po, input logic [7:0] a, input logic [7:0] p);
    @(negedge clk);
    stack_req = '{pu, po, a};
    go;
    chk({stack_mem.rd, stack_mem.wr, stack_mem.addr}, {6'h00, po, pu, a});
    if (pu) chk(16'(stack_mem.wdata), 16'(a));
    chk(16'(stack_top_pointer), 16'(p));
  endtask : stk
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    rst_b = 1'b0;
    pointer_inc = 1'b0;
    sfr_req = '0;
    bit_req = '0;
    alu_req = '0;
    stack_req = '0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    foreach (adr[i]) rd(adr[i], (i == 0) ? 8'h07 : 8'h00);
    rd(8'h85, 8'h00);
    stk(1'b1, 1'b0, 8'h08, 8'h08);
    stk(1'b1, 1'b0, 8'h09, 8'h09);
    stk(1'b0, 1'b1, 8'h09, 8'h08);
    stk(1'b0, 1'b1, 8'h08, 8'h07);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    chk(indirect_pointer, 16'h1234);
    wr(8'h82, 8'hFF);
    @(negedge clk);
    pointer_inc = 1'b1;
    go;
    chk(indirect_pointer, 16'h1300);
    rd(8'h83, 8'h13);
    for (int i = 0; i < 4; i++) begin
      wr(8'hD0, 8'(i * 8));
      chk(16'(bank_base), 16'(i * 8));
    end
    wr(8'hD0, 8'h22);
    wr(8'hE0, 8'hFF);
    alu(CSR_OP_ADD, 8'h01, 8'hE2);
    alu(CSR_OP_SUB_BORROW, 8'h01, 8'hE3);
    chk(16'(primary_operand), 16'h00FE);
    wr(8'hE0, 8'h7F);
    alu(CSR_OP_ADD, 8'h01, 8'h67);
    @(negedge clk);
    bit_req = '{1'b1, 8'hD7, 1'b1};
    go;
    chk(16'(status_word), 16'h00E7);
    alu(CSR_OP_ADD_CARRY, 8'h80, 8'hA7);
    wr(8'hE0, 8'h20);
    wr(8'hF0, 8'h10);
    alu(CSR_OP_PRODUCT, 8'h00, 8'h26);
    chk({secondary_operand, primary_operand}, 16'h0200);
    alu(CSR_OP_PRODUCT, 8'h00, 8'h22);
    wr(8'hE0, 8'h09);
    alu(CSR_OP_DIV, 8'h00, 8'h26);
    wr(8'hF0, 8'h04);
    alu(CSR_OP_DIV, 8'h00, 8'h23);
    chk({secondary_operand, primary_operand}, 16'h0102);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h81, 8'h07);
    end_of_test;
  end
endmodule : tb_cpu_core_special_registers
bind csr_core_regs csr_core_regs_sva i_csr_core_regs_sva (.clk, .rst_b, .sfr_req, .sfr_hit,
  .sfr_rdata, .bit_req, .alu_req, .stack_req, .stack_mem, .pointer_inc, .indirect_pointer,
  .bank_base, .stack_top_pointer, .primary_operand, .secondary_operand, .status_word);
`default_nettype wire

// [verilog/csr_core_regs.sv]
`include "csr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire csr_pkg::csr_sfr_req_t sfr_req,
  output logic sfr_hit,
  output logic [7:0] sfr_rdata,
  input wire csr_pkg::csr_bit_req_t bit_req,
  input wire csr_pkg::csr_alu_req_t alu_req,
  input wire csr_pkg::csr_stack_req_t stack_req,
  output csr_pkg::csr_stack_mem_t stack_mem,
  input wire logic pointer_inc,
  output logic [15:0] indirect_pointer,
  output logic [4:0] bank_base,
  output logic [7:0] stack_top_pointer,
  output logic [7:0] primary_operand,
  output logic [7:0] secondary_operand,
  output logic [7:0] status_word
);
  import csr_pkg::*;

  csr_state_t state_r;
  csr_state_t state_nxt;
  csr_arith_t arith;
  logic [15:0] product;
  logic [15:0] quot_rem;
  logic [7:0] bit_byte;
  logic [15:0] ptr_sum;

  function automatic logic odd_parity(input logic [7:0] v);
    odd_parity = ^v;
  endfunction : odd_parity

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `CSR_STK_ADDR) || (a == `CSR_PLO_ADDR)
             || (a == `CSR_PHI_ADDR) || (a == `CSR_STAT_ADDR)
             || (a == `CSR_ACCUM_ADDR) || (a == `CSR_SEC_ADDR);
  endfunction : is_mapped

  // the stored parity bit is never shown, so it cannot lag the accumulator
  function automatic logic [7:0] status_view(input csr_state_t s);
    logic [7:0] v;
    v = s.status;
    v[`CSR_PAR_BIT] = odd_parity(s.accum);
    status_view = v;
  endfunction : status_view

  // carries come from widened sums, signed overflow from the sign bits
  function automatic csr_arith_t arith_add(
    input logic [7:0] a,
    input logic [7:0] o,
    input logic cin
  );
    logic [8:0] s;
    logic [4:0] n;
    csr_arith_t r;
    s = {1'b0, a} + {1'b0, o} + {8'h00, cin};
    n = {1'b0, a[3:0]} + {1'b0, o[3:0]} + {4'h0, cin};
    r.carry = s[8];
    r.half_carry = n[4];
    r.excess = (a[7] == o[7]) && (s[7] != a[7]);
    r.res = s[7:0];
    arith_add = r;
  endfunction : arith_add

  // a borrow shows as the top bit of the widened difference
  function automatic csr_arith_t arith_sub(
    input logic [7:0] a,
    input logic [7:0] o,
    input logic cin
  );
    logic [8:0] s;
    logic [4:0] n;
    csr_arith_t r;
    s = {1'b0, a} - {1'b0, o} - {8'h00, cin};
    n = {1'b0, a[3:0]} - {1'b0, o[3:0]} - {4'h0, cin};
    r.carry = s[8];
    r.half_carry = n[4];
    r.excess = (a[7] != o[7]) && (s[7] != a[7]);
    r.res = s[7:0];
    arith_sub = r;
  endfunction : arith_sub

  // zero divisor gives back both operands, so no unknowns leak out
  function automatic logic [15:0] divide(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] r;
    r = {d, a};
    if (d != `CSR_ZERO8) begin
      r = {a % d, a / d};
    end
    divide = r;
  endfunction : divide

  // every arithmetic op writes all three flags, so clears need no special case
  function automatic csr_state_t put_flags(input csr_state_t s, input csr_arith_t f);
    csr_state_t r;
    r = s;
    r.status[`CSR_CARRY_BIT] = f.carry;
    r.status[`CSR_HALF_BIT] = f.half_carry;
    r.status[`CSR_EXCESS_BIT] = f.excess;
    put_flags = r;
  endfunction : put_flags

  function automatic logic [7:0] sfr_read(
    input logic [7:0] a,
    input csr_state_t s
  );
    logic [7:0] v;
    v = `CSR_UNMAPPED_RDATA;
    case (a)
      `CSR_STK_ADDR: begin
        v = s.stk_ptr;
      end
      `CSR_PLO_ADDR: begin
        v = s.ptr_lo;
      end
      `CSR_PHI_ADDR: begin
        v = s.ptr_hi;
      end
      `CSR_STAT_ADDR: begin
        v = status_view(s);
      end
      `CSR_ACCUM_ADDR: begin
        v = s.accum;
      end
      `CSR_SEC_ADDR: begin
        v = s.sec;
      end
      default: begin
        v = `CSR_UNMAPPED_RDATA;
      end
    endcase
    sfr_read = v;
  endfunction : sfr_read

  // byte write; unmapped addresses change nothing
  function automatic csr_state_t sfr_write(
    input csr_state_t s,
    input logic [7:0] a,
    input logic [7:0] d
  );
    csr_state_t r;
    r = s;
    case (a)
      `CSR_STK_ADDR: begin
        r.stk_ptr = d;
      end
      `CSR_PLO_ADDR: begin
        r.ptr_lo = d;
      end
      `CSR_PHI_ADDR: begin
        r.ptr_hi = d;
      end
      `CSR_STAT_ADDR: begin
        r.status = d;
      end
      `CSR_ACCUM_ADDR: begin
        r.accum = d;
      end
      `CSR_SEC_ADDR: begin
        r.sec = d;
      end
      default: begin
      end
    endcase
    sfr_write = r;
  endfunction : sfr_write

  // single-bit write; parity position is stored but never shown
  function automatic csr_state_t bit_write(
    input csr_state_t s,
    input logic [7:0] byte_addr,
    input logic [2:0] idx,
    input logic v
  );
    csr_state_t r;
    r = s;
    case (byte_addr)
      `CSR_STAT_ADDR: begin
        r.status[idx] = v;
      end
      `CSR_ACCUM_ADDR: begin
        r.accum[idx] = v;
      end
      `CSR_SEC_ADDR: begin
        r.sec[idx] = v;
      end
      default: begin
      end
    endcase
    bit_write = r;
  endfunction : bit_write

  // pointer wraps modulo 256 in both directions
  function automatic csr_state_t stack_op(
    input csr_state_t s,
    input csr_stack_req_t q
  );
    csr_state_t r;
    r = s;
    // push has priority when both strobes come together
    if (q.push) begin
      r.stk_ptr = s.stk_ptr + `CSR_ONE8;
      r.mem.wr = 1'b1;
      r.mem.addr = s.stk_ptr + `CSR_ONE8;
      r.mem.wdata = q.data;
    end else if (q.pop) begin
      r.mem.rd = 1'b1;
      r.mem.addr = s.stk_ptr;
      r.stk_ptr = s.stk_ptr - `CSR_ONE8;
    end
    stack_op = r;
  endfunction : stack_op

  assign product = {8'h00, state_r.accum} * {8'h00, state_r.sec};
  assign quot_rem = divide(state_r.accum, state_r.sec);
  assign bit_byte = bit_req.addr & `CSR_BIT_BYTE_MASK;
  assign ptr_sum = {state_r.ptr_hi, state_r.ptr_lo} + `CSR_ONE16;

  always_comb begin
    arith = '0;
    case (alu_req.op)
      CSR_OP_ADD: begin
        arith = arith_add(state_r.accum, alu_req.operand, 1'b0);
      end
      CSR_OP_ADD_CARRY: begin
        arith = arith_add(state_r.accum, alu_req.operand,
                          state_r.status[`CSR_CARRY_BIT]);
      end
      CSR_OP_SUB_BORROW: begin
        arith = arith_sub(state_r.accum, alu_req.operand,
                          state_r.status[`CSR_CARRY_BIT]);
      end
      CSR_OP_PRODUCT: begin
        // carry and half carry stay cleared
        arith.excess = |product[15:8];
        arith.res = product[7:0];
      end
      CSR_OP_DIV: begin
        // quotient and remainder are left untouched on divide by zero
        arith.excess = (state_r.sec == `CSR_ZERO8);
        arith.res = quot_rem[7:0];
      end
      default: begin
        arith = '0;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.mem = '0;

    // arithmetic first; a same-cycle register write overrides it below
    case (alu_req.op)
      CSR_OP_ADD, CSR_OP_ADD_CARRY, CSR_OP_SUB_BORROW: begin
        state_nxt = put_flags(state_nxt, arith);
        state_nxt.accum = arith.res;
      end
      CSR_OP_PRODUCT: begin
        state_nxt = put_flags(state_nxt, arith);
        state_nxt.accum = arith.res;
        state_nxt.sec = product[15:8];
      end
      CSR_OP_DIV: begin
        state_nxt = put_flags(state_nxt, arith);
        state_nxt.accum = arith.res;
        state_nxt.sec = quot_rem[15:8];
      end
      default: begin
      end
    endcase

    if (pointer_inc) begin
      state_nxt.ptr_lo = ptr_sum[7:0];
      state_nxt.ptr_hi = ptr_sum[15:8];
    end

    state_nxt = stack_op(state_nxt, stack_req);

    // a pointer write in the same cycle wins, the memory pulse still goes out
    if (sfr_req.wr) begin
      state_nxt = sfr_write(state_nxt, sfr_req.addr, sfr_req.wdata);
    end

    // applied after the byte write, so the bit wins on its position
    if (bit_req.wr) begin
      state_nxt = bit_write(state_nxt, bit_byte, bit_req.addr[2:0], bit_req.value);
    end

    if (sfr_req.rd) begin
      state_nxt.rdata = sfr_read(sfr_req.addr, state_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r.stk_ptr <= `CSR_STK_RST;
      state_r.ptr_lo <= `CSR_PLO_RST;
      state_r.ptr_hi <= `CSR_PHI_RST;
      state_r.status <= `CSR_STAT_RST;
      state_r.accum <= `CSR_ACCUM_RST;
      state_r.sec <= `CSR_SEC_RST;
      state_r.rdata <= `CSR_UNMAPPED_RDATA;
      state_r.mem <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sfr_hit = is_mapped(sfr_req.addr);
  assign sfr_rdata = state_r.rdata;
  assign stack_mem = state_r.mem;
  assign indirect_pointer = {state_r.ptr_hi, state_r.ptr_lo};
  assign bank_base = {state_r.status[`CSR_BANKHI_BIT], state_r.status[`CSR_BANKLO_BIT],
                      `CSR_BANK_PAD};
  assign stack_top_pointer = state_r.stk_ptr;
  assign primary_operand = state_r.accum;
  assign secondary_operand = state_r.sec;
  assign status_word = status_view(state_r);

endmodule : csr_core_regs

`default_nettype wire

// [verilog/csr_defines.svh]
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// register addresses, the same on every register page
`define CSR_STK_ADDR 8'h81
`define CSR_PLO_ADDR 8'h82
`define CSR_PHI_ADDR 8'h83
`define CSR_STAT_ADDR 8'hD0
`define CSR_ACCUM_ADDR 8'hE0
`define CSR_SEC_ADDR 8'hF0

// reset values
`define CSR_STK_RST 8'h07
`define CSR_PLO_RST 8'h00
`define CSR_PHI_RST 8'h00
`define CSR_STAT_RST 8'h00
`define CSR_ACCUM_RST 8'h00
`define CSR_SEC_RST 8'h00

// status word fields
`define CSR_CARRY_BIT 7
`define CSR_HALF_BIT 6
`define CSR_USER0_BIT 5
`define CSR_BANKHI_BIT 4
`define CSR_BANKLO_BIT 3
`define CSR_EXCESS_BIT 2
`define CSR_USER1_BIT 1
`define CSR_PAR_BIT 0

// bit address -> owning byte address
`define CSR_BIT_BYTE_MASK 8'hF8
`define CSR_UNMAPPED_RDATA 8'h00
`define CSR_ZERO8 8'h00
`define CSR_ONE8 8'h01
`define CSR_ONE16 16'h0001
`define CSR_BANK_PAD 3'b000

`endif

// [verilog/csr_pkg.sv]
package csr_pkg;

  typedef enum logic [2:0] {
    CSR_OP_NONE = 3'b000,
    CSR_OP_ADD  = 3'b001,
    CSR_OP_ADD_CARRY = 3'b010,
    CSR_OP_SUB_BORROW = 3'b011,
    CSR_OP_PRODUCT = 3'b100,
    CSR_OP_DIV  = 3'b101
  } csr_alu_op_t;

  typedef struct packed {
    csr_alu_op_t op;
    logic [7:0] operand;
  } csr_alu_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_sfr_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic value;
  } csr_bit_req_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] data;
  } csr_stack_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_stack_mem_t;

  typedef struct packed {
    logic carry;
    logic half_carry;
    logic excess;
    logic [7:0] res;
  } csr_arith_t;

  typedef struct packed {
    logic [7:0] stk_ptr;
    logic [7:0] ptr_lo;
    logic [7:0] ptr_hi;
    logic [7:0] status;
    logic [7:0] accum;
    logic [7:0] sec;
    logic [7:0] rdata;
    csr_stack_mem_t mem;
  } csr_state_t;

endpackage : csr_pkg
